/* src/dam_regs.svh */
// Constants for the dual converter output and mode control link.
// Behaviour
// [R1] Forwarded clock driven when enable low.
// [R2] Format select 0 offset binary, 1 twos.
// [R3] Power-down low stops both channels.
// [R4] Power-down forces all digital outputs zero.
// [R5] Host asserts power-down before first activation.
// [R6] Active-low enable tristates channel data outputs.
// [R7] Overrange flag high when input exceeds range.
// [R8] Two-bit bias: off, 50uA, 500uA, 1mA.
// [R9] Sleep code: bit0 channel 0, bit1 channel 1.
// [R10] Bit 0 is LSB; capture 13 bits.
// [R11] 12-bit 2Vpp use: bit 1 LSB.
// [R12] At 2Vpp bit 12 is MSB.
// [R13] At 1Vpp bit 11 MSB, bit 0 LSB.
// [R14] Receiver samples data against forwarded clock.
// [R15] Valid samples within 900 cycles after power-down.
// [R16] Valid samples within 20 cycles after sleep.
// [R17] Overrange recovery within one sample cycle.
// [R18] Only rising sample clock edge is used.
// [R19] Overrange flag aligned with its data word.
// [R20] Sleeping channel outputs hold static value.
`ifndef DAM_REGS_SVH
`define DAM_REGS_SVH
`define DAM_DW 13
`define DAM_FMT_TWOS 1'h1
`define DAM_PD_START_CYC 10'h384
`define DAM_SLP_START_CYC 5'h14
`define DAM_PD_LEAD_CYC 10'h006
`define DAM_SLP_LEAD_CYC 5'h06
`define DAM_PHASE_LAST 2'h3
`define DAM_PHASE_HIGH 2'h2
`define DAM_HOST_PD_HOLD 5'h10
`define DAM_SYNC_W 29
`endif

/* src/dam_pkg.sv */
// Types and shared helpers for the dual converter link.
package dam_pkg;
`include "dam_regs.svh"
    typedef logic [`DAM_DW-1:0] dam_word_t;
    typedef enum logic [1:0] {
        DAM_BIAS_OFF = 2'h0,
        DAM_BIAS_50UA = 2'h1,
        DAM_BIAS_500UA = 2'h2,
        DAM_BIAS_1MA = 2'h3
    } dam_bias_t;
    typedef enum logic [0:0] {
        DAM_HS_INIT = 1'h0,
        DAM_HS_RUN = 1'h1
    } dam_hstate_t;

    // Turns an offset binary code into the selected output format.
    function automatic dam_word_t dam_encode(dam_word_t code, logic fmt);
        dam_word_t w;
        w = code;
        if (fmt == `DAM_FMT_TWOS) begin
            w[`DAM_DW-1] = ~code[`DAM_DW-1];
        end
        return w;
    endfunction
endpackage

/* src/dam_if.sv */
// Pin bundle between the converter and its capture logic.
`timescale 1ns/100ps
interface dam_if;
    logic fwd_out_clock;
    logic fwd_out_oe;
    logic [12:0] ch0_data_out;
    logic [12:0] ch1_data_out;
    logic ch0_data_oe;
    logic ch1_data_oe;
    logic ch0_overrange_flag;
    logic ch1_overrange_flag;
    logic number_format_sel;
    logic chip_powerdown_n;
    logic sleep_ctl_lo;
    logic sleep_ctl_hi;
    logic cm_bias_ctl_lo;
    logic cm_bias_ctl_hi;
    logic fwd_clock_enable_n;
    logic ch0_oe_n;
    logic ch1_oe_n;
    wire fwd_out_clock_bus;
    wire [12:0] ch0_data_bus;
    wire [12:0] ch1_data_bus;

    // A released pin has no pull resistor and floats; it is shown as the
    // inverse of the driven level, so a capture of it reads as wrong data.
    assign fwd_out_clock_bus = fwd_out_oe ? fwd_out_clock : ~fwd_out_clock;
    assign ch0_data_bus = ch0_data_oe ? ch0_data_out : ~ch0_data_out;
    assign ch1_data_bus = ch1_data_oe ? ch1_data_out : ~ch1_data_out;

    modport device (
        output fwd_out_clock, fwd_out_oe, ch0_data_out, ch1_data_out,
        output ch0_data_oe, ch1_data_oe,
        output ch0_overrange_flag, ch1_overrange_flag,
        input number_format_sel, chip_powerdown_n, sleep_ctl_lo,
        input sleep_ctl_hi, cm_bias_ctl_lo, cm_bias_ctl_hi,
        input fwd_clock_enable_n, ch0_oe_n, ch1_oe_n
    );
    modport host (
        input fwd_out_clock_bus, ch0_data_bus, ch1_data_bus,
        input ch0_overrange_flag, ch1_overrange_flag,
        output number_format_sel, chip_powerdown_n, sleep_ctl_lo,
        output sleep_ctl_hi, cm_bias_ctl_lo, cm_bias_ctl_hi,
        output fwd_clock_enable_n, ch0_oe_n, ch1_oe_n
    );
endinterface

/* src/dam_sync.sv */
// Two flip-flop synchroniser for a group of levels.
`timescale 1ns/100ps
module dam_sync
    import dam_pkg::*;
#(
    parameter int W = 9
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Levels in and out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dam_sync_t;
    dam_sync_t s_r;
    dam_sync_t s_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        s_nxt.meta = d;
        s_nxt.stable = s_r.meta;
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stable;
endmodule

/* src/dam_dev.sv */
// Converter end: mode decode, output formatting and forwarded clock.
`timescale 1ns/100ps
module dam_dev
    import dam_pkg::*;
(
    // Sample clock and power-on reset.
    input wire logic sample_clock_pos,
    input wire logic resetn,
    // Pins toward the capture logic.
    dam_if.device pins,
    // Converted codes from the analog core, offset binary.
    input wire logic [12:0] ch0_code,
    input wire logic [12:0] ch1_code,
    input wire logic ch0_over,
    input wire logic ch1_over,
    // Mode status toward the analog core.
    output dam_bias_t cm_bias_level,
    output logic [1:0] chan_awake
);
    typedef struct packed {
        logic [1:0] phase;
        logic fwd;
        logic fwd_oe;
        logic [1:0] oe;
        logic [1:0][12:0] data;
        logic [1:0] flag;
        logic [9:0] pd_cnt;
        logic [1:0][4:0] slp_cnt;
        logic [1:0] awake;
        dam_bias_t bias;
    } dam_dev_t;
    dam_dev_t s_r;
    dam_dev_t s_nxt;
    logic [8:0] pins_raw;
    logic [8:0] pins_s;
    logic pd;
    logic fmt;
    logic [1:0] slp;
    logic [1:0][12:0] code;
    logic [1:0] over;
    logic [4:0] slp_reload;

    // Control pins come from the host clock and are synchronised.
    assign pins_raw = {pins.chip_powerdown_n, pins.number_format_sel,
                       pins.sleep_ctl_hi, pins.sleep_ctl_lo,
                       pins.cm_bias_ctl_hi, pins.cm_bias_ctl_lo,
                       pins.fwd_clock_enable_n, pins.ch1_oe_n,
                       pins.ch0_oe_n};

    dam_sync #(.W(9)) u_sync (
        .clk(sample_clock_pos),
        .resetn(resetn),
        .d(pins_raw),
        .q(pins_s)
    );

    assign pd = ~pins_s[8];
    assign fmt = pins_s[7];
    assign slp = pins_s[6:5];
    assign code = {ch1_code, ch0_code};
    assign over = {ch1_over, ch0_over};

    // Warm-up counts are shortened by the pin synchroniser and the worst
    // wait for the next load phase, so the first word meets the limit.
    assign slp_reload = `DAM_SLP_START_CYC - `DAM_SLP_LEAD_CYC; // see [R16]

    // Next state of the output stage, one word load per four clock edges.
    always_comb begin
        s_nxt = s_r;
        s_nxt.fwd_oe = ~pins_s[2]; // see [R1]
        s_nxt.oe = ~pins_s[1:0]; // see [R6]
        s_nxt.bias = dam_bias_t'(pins_s[4:3]); // see [R8]
        if (pd) begin
            // Power-down stops conversion and zeroes the clock, data and flag outputs.
            s_nxt.phase = 2'h0; // see [R3]
            s_nxt.fwd = 1'h0; // see [R4]
            s_nxt.data = '0; // see [R4]
            s_nxt.flag = '0; // see [R4]
            s_nxt.awake = 2'h0;
            s_nxt.pd_cnt = `DAM_PD_START_CYC - `DAM_PD_LEAD_CYC; // see [R15]
            s_nxt.slp_cnt = {2{slp_reload}};
        end else begin
            s_nxt.phase = s_r.phase + 2'h1;
            s_nxt.fwd = (s_nxt.phase >= `DAM_PHASE_HIGH); // see [R14]
            s_nxt.awake = slp; // see [R9]
            if (s_r.pd_cnt != 10'h000) begin
                s_nxt.pd_cnt = s_r.pd_cnt - 10'h001; // see [R15]
            end
            for (int c = 0; c < 2; c++) begin
                if (!slp[c]) begin
                    s_nxt.slp_cnt[c] = slp_reload; // see [R16]
                end else if (s_r.slp_cnt[c] != 5'h00) begin
                    s_nxt.slp_cnt[c] = s_r.slp_cnt[c] - 5'h01; // see [R16]
                end
                // Data and flag change together as fwd clock falls.
                if (s_r.phase == `DAM_PHASE_LAST && s_r.pd_cnt == 10'h000 &&
                    slp[c] && s_r.slp_cnt[c] == 5'h00) begin
                    s_nxt.data[c] = dam_encode(code[c], fmt); // see [R2]
                    s_nxt.flag[c] = over[c]; // see [R7] [R17] [R19]
                end
                // Asleep or warming up: words hold their last value.
            end
        end
    end

    // State register on the rising sample clock edge only.
    always_ff @(posedge sample_clock_pos or negedge resetn) begin // see [R18]
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt; // see [R20]
        end
    end

    // Pin and status drivers, all straight from flip-flops.
    assign pins.fwd_out_clock = s_r.fwd;
    assign pins.fwd_out_oe = s_r.fwd_oe;
    assign pins.ch0_data_out = s_r.data[0]; // see [R10] [R12] [R13]
    assign pins.ch1_data_out = s_r.data[1];
    assign pins.ch0_data_oe = s_r.oe[0];
    assign pins.ch1_data_oe = s_r.oe[1];
    assign pins.ch0_overrange_flag = s_r.flag[0];
    assign pins.ch1_overrange_flag = s_r.flag[1];
    assign cm_bias_level = s_r.bias;
    assign chan_awake = s_r.awake;
endmodule

/* src/dam_host.sv */
// Capture end: drives the mode pins and captures both channels.
`timescale 1ns/100ps
module dam_host
    import dam_pkg::*;
(
    // System clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Pins toward the converter.
    dam_if.host pins,
    // Requested modes.
    input wire logic req_powerdown_n,
    input wire logic req_format,
    input wire logic [1:0] req_sleep,
    input wire dam_bias_t req_bias,
    input wire logic req_fwd_enable_n,
    input wire logic [1:0] req_oe_n,
    input wire logic range_1vpp,
    // Captured samples.
    output logic [12:0] ch0_word,
    output logic [12:0] ch1_word,
    output logic [11:0] ch0_word12,
    output logic [11:0] ch1_word12,
    output logic [1:0] over_flags,
    output logic sample_valid
);
    typedef struct packed {
        dam_hstate_t st;
        logic [4:0] hold;
        logic pd_n;
        logic fmt;
        logic [1:0] slp;
        logic [1:0] bias;
        logic fwd_en_n;
        logic [1:0] oe_n;
        logic fwd_prev;
        logic [1:0][12:0] word;
        logic [1:0][11:0] word12;
        logic [1:0] flag;
        logic valid;
    } dam_host_t;
    dam_host_t s_r;
    dam_host_t s_nxt;
    logic [`DAM_SYNC_W-1:0] in_raw;
    logic [`DAM_SYNC_W-1:0] in_s;
    logic fwd_s;
    logic [1:0][12:0] data_s;
    logic [1:0] flag_s;

    // Every input pin passes two flops, so skew stays within one cycle.
    assign in_raw = {pins.fwd_out_clock_bus, pins.ch1_overrange_flag,
                     pins.ch0_overrange_flag, pins.ch1_data_bus,
                     pins.ch0_data_bus};

    dam_sync #(.W(`DAM_SYNC_W)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d(in_raw),
        .q(in_s)
    );

    assign fwd_s = in_s[28];
    assign flag_s = in_s[27:26];
    assign data_s = in_s[25:0];

    // Pin control and capture on the rising forwarded clock.
    always_comb begin
        s_nxt = s_r;
        s_nxt.fmt = req_format;
        s_nxt.slp = req_sleep;
        s_nxt.bias = req_bias;
        s_nxt.fwd_en_n = req_fwd_enable_n;
        s_nxt.oe_n = req_oe_n;
        s_nxt.fwd_prev = fwd_s;
        s_nxt.valid = 1'h0;
        unique case (s_r.st)
            DAM_HS_INIT: begin
                // Power-down is held after reset before any activation.
                s_nxt.pd_n = 1'h0; // see [R5]
                s_nxt.hold = s_r.hold + 5'h01;
                if (s_r.hold == `DAM_HOST_PD_HOLD) begin
                    s_nxt.st = DAM_HS_RUN;
                end
            end
            DAM_HS_RUN: begin
                s_nxt.pd_n = req_powerdown_n;
            end
        endcase
        if (fwd_s && !s_r.fwd_prev) begin
            s_nxt.valid = 1'h1; // see [R14]
            s_nxt.flag = flag_s;
            for (int c = 0; c < 2; c++) begin
                s_nxt.word[c] = data_s[c]; // see [R10]
                if (range_1vpp) begin
                    s_nxt.word12[c] = data_s[c][11:0]; // see [R13]
                end else begin
                    s_nxt.word12[c] = data_s[c][12:1]; // see [R11] [R12]
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pin and result drivers, all straight from flip-flops.
    assign pins.chip_powerdown_n = s_r.pd_n;
    assign pins.number_format_sel = s_r.fmt;
    assign pins.sleep_ctl_lo = s_r.slp[0];
    assign pins.sleep_ctl_hi = s_r.slp[1];
    assign pins.cm_bias_ctl_lo = s_r.bias[0];
    assign pins.cm_bias_ctl_hi = s_r.bias[1];
    assign pins.fwd_clock_enable_n = s_r.fwd_en_n;
    assign pins.ch0_oe_n = s_r.oe_n[0];
    assign pins.ch1_oe_n = s_r.oe_n[1];
    assign ch0_word = s_r.word[0];
    assign ch1_word = s_r.word[1];
    assign ch0_word12 = s_r.word12[0];
    assign ch1_word12 = s_r.word12[1];
    assign over_flags = s_r.flag;
    assign sample_valid = s_r.valid;
endmodule

/* tb/dam_chk_sva.sv */
// Concurrent checks on the pins between converter and capture logic.
`timescale 1ns/100ps
module dam_chk (
    // Sample clock and reset.
    input wire logic sample_clock_pos,
    input wire logic resetn,
    // Converter outputs.
    input wire logic fwd_out_clock,
    input wire logic fwd_out_oe,
    input wire logic [12:0] ch0_data_out,
    input wire logic [12:0] ch1_data_out,
    input wire logic ch0_data_oe,
    input wire logic ch1_data_oe,
    input wire logic ch0_overrange_flag,
    input wire logic ch1_overrange_flag,
    // Capture logic outputs.
    input wire logic chip_powerdown_n,
    input wire logic sleep_ctl_lo,
    input wire logic sleep_ctl_hi,
    input wire logic fwd_clock_enable_n,
    input wire logic ch0_oe_n,
    input wire logic ch1_oe_n
);
    // All checks run on the sample clock; pins need three edges to land.
    default clocking cb @(posedge sample_clock_pos);
    endclocking
    default disable iff (!resetn);
    // One forwarded clock period after a rise: high, two low, high again.
    sequence fwd_period;
        fwd_out_clock ##1 !fwd_out_clock [*2] ##1 fwd_out_clock;
    endsequence
    // Words are loaded on the falling forwarded clock edge only.
    sequence load_edge;
        $fell(fwd_out_clock);
    endsequence
    AST_FWD_ON:
    assert property ((!fwd_clock_enable_n) [*6] |-> fwd_out_oe)
        else $error("forwarded clock not driven");
    AST_OE0_OFF:
    assert property (ch0_oe_n [*6] |-> !ch0_data_oe)
        else $error("channel 0 data still driven");
    AST_OE1_OFF:
    assert property (ch1_oe_n [*6] |-> !ch1_data_oe)
        else $error("channel 1 data still driven");
    AST_PD_ZERO:
    assert property ((!chip_powerdown_n) [*6] |-> !(|{ch0_data_out,
        ch1_data_out, ch0_overrange_flag, ch1_overrange_flag, fwd_out_clock}))
        else $error("outputs not zero in power-down");
    AST_FWD_PERIOD:
    assert property (disable iff (!resetn || !chip_powerdown_n)
        $rose(fwd_out_clock) |=> fwd_period)
        else $error("forwarded clock period broken");
    AST_ALIGN:
    assert property (disable iff (!resetn || !chip_powerdown_n)
        ($changed({ch0_data_out, ch1_data_out}) || $changed({
        ch0_overrange_flag, ch1_overrange_flag})) |-> load_edge)
        else $error("word or flag changed off the load edge");
    AST_SLEEP0:
    assert property (disable iff (!resetn || !chip_powerdown_n)
        (!sleep_ctl_lo) [*8] |-> $stable({ch0_data_out, ch0_overrange_flag}))
        else $error("sleeping channel 0 changed");
    AST_SLEEP1:
    assert property (disable iff (!resetn || !chip_powerdown_n)
        (!sleep_ctl_hi) [*8] |-> $stable({ch1_data_out, ch1_overrange_flag}))
        else $error("sleeping channel 1 changed");
endmodule

/* tb/testbench.sv */
// Self-checking bench joining the converter end and the capture end.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module testbench import dam_pkg::*;;
    typedef struct packed {
        logic fmt, rng;
        logic [1:0] slp;
        logic [12:0] c0, c1;
        logic o0, o1;
    } dam_row_t;
    // Each row: format, range, sleep code, both codes and both over levels.
    dam_row_t rows [6] = '{
        '{1'h0, 1'h0, 2'h3, 13'h0001, 13'h1FFF, 1'h0, 1'h1},
        '{1'h1, 1'h0, 2'h3, 13'h1000, 13'h0FFF, 1'h1, 1'h0},
        '{1'h0, 1'h1, 2'h1, 13'h0ABC, 13'h1555, 1'h0, 1'h0},
        '{1'h1, 1'h1, 2'h2, 13'h1234, 13'h0321, 1'h1, 1'h1},
        '{1'h0, 1'h0, 2'h0, 13'h1111, 13'h0222, 1'h0, 1'h0},
        '{1'h0, 1'h0, 2'h3, 13'h0F0F, 13'h10F0, 1'h0, 1'h0}};
    logic clk = 1'h0, sample_clock_pos = 1'h0, resetn = 1'h0;
    logic req_powerdown_n = 1'h1, req_format = 1'h0, range_1vpp = 1'h0;
    logic req_fwd_enable_n = 1'h0, ch0_over = 1'h0, ch1_over = 1'h0;
    logic [1:0] req_sleep = 2'h3, req_oe_n = 2'h0;
    dam_bias_t req_bias = DAM_BIAS_OFF;
    dam_bias_t cm_bias_level;
    logic [12:0] ch0_code = 13'h0001, ch1_code = 13'h0002;
    logic [12:0] ch0_word, ch1_word;
    logic [11:0] ch0_word12, ch1_word12;
    logic [1:0] chan_awake, over_flags, pin_flags;
    logic sample_valid;
    int num_errors = 0, comparisons = 0;
    dam_if pins_if ();
    // Both flag pins as one value, channel 1 in the upper bit.
    assign pin_flags = {pins_if.ch1_overrange_flag,
                        pins_if.ch0_overrange_flag};
    dam_dev dam_dev_i (.sample_clock_pos(sample_clock_pos), .resetn(resetn),
        .pins(pins_if.device), .ch0_code(ch0_code), .ch1_code(ch1_code),
        .ch0_over(ch0_over), .ch1_over(ch1_over),
        .cm_bias_level(cm_bias_level), .chan_awake(chan_awake));
    dam_host dam_host_i (.clk(clk), .resetn(resetn), .pins(pins_if.host),
        .req_powerdown_n(req_powerdown_n), .req_format(req_format),
        .req_sleep(req_sleep), .req_bias(req_bias),
        .req_fwd_enable_n(req_fwd_enable_n), .req_oe_n(req_oe_n),
        .range_1vpp(range_1vpp), .ch0_word(ch0_word), .ch1_word(ch1_word),
        .ch0_word12(ch0_word12), .ch1_word12(ch1_word12),
        .over_flags(over_flags), .sample_valid(sample_valid));
    dam_chk dam_chk_i (.sample_clock_pos(sample_clock_pos), .resetn(resetn),
        .fwd_out_clock(pins_if.fwd_out_clock),
        .fwd_out_oe(pins_if.fwd_out_oe),
        .ch0_data_out(pins_if.ch0_data_out),
        .ch1_data_out(pins_if.ch1_data_out),
        .ch0_data_oe(pins_if.ch0_data_oe), .ch1_data_oe(pins_if.ch1_data_oe),
        .ch0_overrange_flag(pins_if.ch0_overrange_flag),
        .ch1_overrange_flag(pins_if.ch1_overrange_flag),
        .chip_powerdown_n(pins_if.chip_powerdown_n),
        .sleep_ctl_lo(pins_if.sleep_ctl_lo),
        .sleep_ctl_hi(pins_if.sleep_ctl_hi),
        .fwd_clock_enable_n(pins_if.fwd_clock_enable_n),
        .ch0_oe_n(pins_if.ch0_oe_n), .ch1_oe_n(pins_if.ch1_oe_n));
    // System clock at 10 ns and an unrelated sample clock at 15 ns.
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #3;
        forever #7.5 sample_clock_pos = ~sample_clock_pos;
    end
    // Expected output word; two's complement is the code less half scale.
    function automatic logic [12:0] enc(input logic [12:0] c, input logic f);
        return f ? c - 13'h1000 : c;
    endfunction
    // Prints the counts and the verdict, then stops the run.
    task automatic tally_and_finish();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Waits for n captures, each within a bounded number of clocks.
    task automatic wait_valid(input int n);
        int t;
        repeat (n) begin
            t = 0;
            do begin
                @(posedge clk);
                #1;
                t++;
            end while (sample_valid !== 1'h1 && t < 20);
            `CHK("valid", 1'h1, sample_valid)
        end
    endtask
    // Counts sample clocks until a nonzero word appears on channel 0.
    task automatic startup(input int bound);
        int n;
        n = 0;
        while (pins_if.ch0_data_bus === 13'h0000 && n < bound) begin
            @(posedge sample_clock_pos);
            #1;
            n++;
        end
        `CHK("startup", 1'h1, n < bound)
    endtask
    // Main sequence: reset, table of modes, then the awkward cases.
    initial begin
        dam_row_t r;
        logic [12:0] w0, w1;
        logic [1:0] ef;
        w0 = 13'h0000;
        w1 = 13'h0000;
        ef = 2'h0;
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'h1;
        repeat (8) @(posedge clk);
        #1;
        `CHK("pd_hold", 1'h0, pins_if.chip_powerdown_n)
        startup(912);
        foreach (rows[i]) begin
            r = rows[i];
            req_sleep = r.slp;
            wait_valid(3);
            {req_format, range_1vpp} = {r.fmt, r.rng};
            req_bias = dam_bias_t'(2'(i));
            {ch0_code, ch1_code} = {r.c0, r.c1};
            {ch0_over, ch1_over} = {r.o0, r.o1};
            if (r.slp[0]) {w0, ef[0]} = {enc(r.c0, r.fmt), r.o0};
            if (r.slp[1]) {w1, ef[1]} = {enc(r.c1, r.fmt), r.o1};
            wait_valid(10);
            `CHK("word0", w0, ch0_word)
            `CHK("word1", w1, ch1_word)
            `CHK("w12_0", r.rng ? w0[11:0] : w0[12:1], ch0_word12)
            `CHK("w12_1", r.rng ? w1[11:0] : w1[12:1], ch1_word12)
            `CHK("flags", ef, over_flags)
            `CHK("bias", 2'(i), cm_bias_level)
            `CHK("awake", r.slp, chan_awake)
        end
        // Released drivers hand the pins back; both flags are raised first
        // so that the power-down check below has ones to clear.
        req_fwd_enable_n = 1'h1;
        req_oe_n = 2'h3;
        {ch0_over, ch1_over} = 2'h3;
        repeat (20) @(posedge clk);
        #1;
        `CHK("fwd_z", 1'h0, pins_if.fwd_out_oe)
        `CHK("d0_z", 1'h0, pins_if.ch0_data_oe)
        `CHK("d1_z", 1'h0, pins_if.ch1_data_oe)
        `CHK("fl_set", 2'h3, pin_flags)
        {req_fwd_enable_n, req_oe_n, req_powerdown_n} = 4'h0;
        repeat (10) @(posedge clk);
        #1;
        `CHK("pd_fwd", 1'h0, pins_if.fwd_out_clock_bus)
        `CHK("pd_d0", 13'h0000, pins_if.ch0_data_bus)
        `CHK("pd_d1", 13'h0000, pins_if.ch1_data_bus)
        `CHK("pd_fl", 2'h0, pin_flags)
        req_powerdown_n = 1'h1;
        startup(905);
        tally_and_finish();
    end
    // Cuts a hang short well past the expected run time.
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
endmodule
